/* hw/dpsm_map.svh */
// Functional notes
// R1: Commands via command word, state via state word
// R2: Decode shutdown, switch on, enable operation patterns
// R3: Bit1 clear disables voltage; bit2 clear quick-stops
// R4: Fault reset and quick-stop return edge-triggered
// R5: State word patterns for the six normal states
// R6: Fault reaction and fault state word patterns
// R7: After self-test pass enter switch-on disabled
// R8: Requested mode and active mode held separately
// R9: Mode request accepted in any state
// R10: Quick stop option 0 switches driver off
// R11: Options 1/2 ramp then switch-on disabled
// R12: Options 5/6 ramp then stay energized
// R13: Limit switch also forces quick stop
// R14: Shutdown option: 0 immediate, 1 ramp
// R15: Disable operation option: 0 immediate, 1 ramp
// R16: Fault reaction ramp, then fault, error code kept
// R17: Command bit 7 rising edge resets fault
// R18: Unmatched command word keeps current state
`ifndef DPSM_MAP_SVH
`define DPSM_MAP_SVH

// Register offsets
`define DPSM_OFF_CMD       16'h6040
`define DPSM_OFF_STATE     16'h6041
`define DPSM_OFF_MODE_REQ  16'h6060
`define DPSM_OFF_MODE_ACT  16'h6061
`define DPSM_OFF_QS_OPT    16'h605A
`define DPSM_OFF_SD_OPT    16'h605B
`define DPSM_OFF_DO_OPT    16'h605C
`define DPSM_OFF_FR_OPT    16'h605E
`define DPSM_OFF_ERR_CODE  16'h1003
`define DPSM_OFF_IRQ_STAT  16'h2000
`define DPSM_OFF_IRQ_CLR   16'h2001
`define DPSM_OFF_IRQ_EN    16'h2002

// Reset values
`define DPSM_RST_CMD       16'h0000
`define DPSM_RST_MODE      8'h00
`define DPSM_RST_QS_OPT    16'h0002
`define DPSM_RST_SD_OPT    16'h0001
`define DPSM_RST_DO_OPT    16'h0001
`define DPSM_RST_FR_OPT    16'h0002

// Command word bit positions
`define DPSM_CMD_SWON      0
`define DPSM_CMD_VOLT      1
`define DPSM_CMD_QSTOP     2
`define DPSM_CMD_ENOP      3
`define DPSM_CMD_FRESET    7

// State word codes
`define DPSM_SW_NOT_READY  16'h0000
`define DPSM_SW_SOD        16'h0040
`define DPSM_SW_READY      16'h0021
`define DPSM_SW_SWON       16'h0023
`define DPSM_SW_OPEN       16'h0027
`define DPSM_SW_QSTOP      16'h0007
`define DPSM_SW_FREACT     16'h000F
`define DPSM_SW_FAULT      16'h0008

// Reaction option values
`define DPSM_OPT_OFF       16'h0000
`define DPSM_OPT_NORMAL    16'h0001
`define DPSM_OPT_QUICK     16'h0002
`define DPSM_OPT_NORM_HOLD 16'h0005
`define DPSM_OPT_QUICK_HOLD 16'h0006

// Interrupt event bits
`define DPSM_EV_CHANGE     0
`define DPSM_EV_FAULT      1
`define DPSM_EV_LIMIT      2
`define DPSM_EV_RAMP       3
`define DPSM_EV_W          4

`endif

/* hw/dpsm_pkg.sv */
package dpsm_pkg;

  // Power states
  typedef enum logic [2:0] {
    ST_NOT_READY,
    ST_SOD,
    ST_READY,
    ST_SWON,
    ST_OPEN,
    ST_QSTOP,
    ST_FREACT,
    ST_FAULT
  } dpsm_state_t;

  // Deceleration ramp request
  typedef enum logic [1:0] {
    RAMP_NONE,
    RAMP_NORMAL,
    RAMP_QUICK
  } dpsm_ramp_t;

endpackage

/* hw/dpsm_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dpsm_map.svh"

module dpsm_top #(
  parameter int MODE_W = 8
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Register port
  input  wire logic [15:0] addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // Drive side
  input  wire logic        self_test_ok_i,
  input  wire logic        limit_switch_i,
  input  wire logic        fault_i,
  input  wire logic [15:0] fault_code_i,
  input  wire logic        ramp_done_i,
  output logic             drive_enable_o,
  output logic      [1:0]  brake_ramp_o,
  output logic      [MODE_W-1:0] mode_active_o,
  // Interrupt
  output logic             irq_o
);
  // Refuse widths the 16-bit register port cannot carry
  if (MODE_W < 1 || MODE_W > 16) begin : g_mode_w_check
    $error("MODE_W must lie between 1 and 16");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  ////////////////////////////////////////////////////////////////////////////

  dpsm_pkg::dpsm_state_t state;         // Current power state
  dpsm_pkg::dpsm_state_t next_state;
  dpsm_pkg::dpsm_state_t tgt;           // State reached after the ramp
  dpsm_pkg::dpsm_state_t next_tgt;
  dpsm_pkg::dpsm_ramp_t  ramp;          // Ramp being used
  dpsm_pkg::dpsm_ramp_t  next_ramp;
  logic              brk;               // Braking in progress
  logic              next_brk;
  logic              hold;              // Quick stop held energized
  logic              next_hold;
  logic              drv;               // Driver energized
  logic              next_drv;
  logic [15:0]       cmd;               // Command word
  logic [15:0]       next_cmd;
  logic [15:0]       cmd_prev;          // Command word one cycle back
  logic [MODE_W-1:0] mode_req;          // Requested mode
  logic [MODE_W-1:0] next_mode_req;
  logic [MODE_W-1:0] mode_act;          // Mode in force
  logic [MODE_W-1:0] next_mode_act;
  logic [15:0]       qs_opt;            // Quick stop reaction
  logic [15:0]       next_qs_opt;
  logic [15:0]       sd_opt;            // Shutdown reaction
  logic [15:0]       next_sd_opt;
  logic [15:0]       do_opt;            // Disable operation reaction
  logic [15:0]       next_do_opt;
  logic [15:0]       fr_opt;            // Fault reaction
  logic [15:0]       next_fr_opt;
  logic [15:0]       err_code;          // Last error code
  logic [15:0]       next_err_code;
  logic [`DPSM_EV_W-1:0] irq_stat;      // Sticky events
  logic [`DPSM_EV_W-1:0] next_irq_stat;
  logic [`DPSM_EV_W-1:0] irq_en;        // Event enables
  logic [`DPSM_EV_W-1:0] next_irq_en;
  logic [`DPSM_EV_W-1:0] evt;           // Events this cycle
  logic [15:0]       rdata;             // Read data flop
  logic [15:0]       next_rdata;
  logic [15:0]       state_word;        // Encoded state
  logic              lim_s1;            // Limit synchroniser stage 1
  logic              lim_s2;            // Limit synchroniser stage 2
  logic              lim_prev;          // Limit level one cycle back
  logic              lim_hit;           // Limit rising edge
  // Command decode
  logic c_lock;                         // Bit 7 set blocks normal commands
  logic c_dis_volt;
  logic c_qstop;
  logic c_shutdown;
  logic c_switch_on;
  logic c_enable;
  logic e_freset;                       // Rising edge of bit 7
  logic e_qs_ret;                       // Rising edge of bit 2

  ////////////////////////////////////////////////////////////////////////////
  // Input conditioning and command decode
  ////////////////////////////////////////////////////////////////////////////

  // Limit switch is a pin: two flops before use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lim_s1   <= 1'b0;
      lim_s2   <= 1'b0;
      lim_prev <= 1'b0;
      cmd_prev <= `DPSM_RST_CMD;
    end else begin
      lim_s1   <= limit_switch_i;
      lim_s2   <= lim_s1;
      lim_prev <= lim_s2;
      cmd_prev <= cmd;
    end
  end
  assign lim_hit = lim_s2 & ~lim_prev;
  // Level decode with bit 7 clear; don't-care bits ignored
  assign c_lock      = cmd[`DPSM_CMD_FRESET];
  assign c_dis_volt  = ~c_lock & ~cmd[`DPSM_CMD_VOLT]; // see R3
  assign c_qstop     = ~c_lock & ~cmd[`DPSM_CMD_QSTOP] & cmd[`DPSM_CMD_VOLT]; // see R3
  assign c_shutdown  = ~c_lock & cmd[`DPSM_CMD_QSTOP] & cmd[`DPSM_CMD_VOLT]
                       & ~cmd[`DPSM_CMD_SWON]; // see R2
  assign c_switch_on = ~c_lock & ~cmd[`DPSM_CMD_ENOP] & cmd[`DPSM_CMD_QSTOP]
                       & cmd[`DPSM_CMD_VOLT] & cmd[`DPSM_CMD_SWON]; // see R2
  assign c_enable    = ~c_lock & cmd[`DPSM_CMD_ENOP] & cmd[`DPSM_CMD_QSTOP]
                       & cmd[`DPSM_CMD_VOLT] & cmd[`DPSM_CMD_SWON]; // see R2
  // Edge requests, never the level
  assign e_freset = cmd[`DPSM_CMD_FRESET] & ~cmd_prev[`DPSM_CMD_FRESET]; // see R4 R17
  assign e_qs_ret = c_enable & ~cmd_prev[`DPSM_CMD_QSTOP]; // see R4

  ////////////////////////////////////////////////////////////////////////////
  // Power state machine
  ////////////////////////////////////////////////////////////////////////////

  // Next state, braking and driver
  always_comb begin
    next_state    = state;
    next_tgt      = tgt;
    next_ramp     = ramp;
    next_brk      = brk;
    next_hold     = hold;
    next_err_code = err_code;
    if (fault_i && state != dpsm_pkg::ST_NOT_READY
        && state != dpsm_pkg::ST_FREACT && state != dpsm_pkg::ST_FAULT) begin
      // Error: react per fault option, keep the code
      next_state    = dpsm_pkg::ST_FREACT; // see R16
      next_err_code = fault_code_i; // see R16
      next_tgt      = dpsm_pkg::ST_FAULT;
      next_hold     = 1'b0;
      next_brk      = (fr_opt == `DPSM_OPT_NORMAL) || (fr_opt == `DPSM_OPT_QUICK);
      next_ramp     = (fr_opt == `DPSM_OPT_QUICK) ? dpsm_pkg::RAMP_QUICK : dpsm_pkg::RAMP_NORMAL;
    end else begin
      case (state)
        dpsm_pkg::ST_NOT_READY: begin
          // Wait for the self-test
          if (self_test_ok_i) begin
            next_state = dpsm_pkg::ST_SOD; // see R7
          end
        end
        dpsm_pkg::ST_SOD: begin
          // Transition 2
          if (c_shutdown) begin
            next_state = dpsm_pkg::ST_READY; // see R2
          end
        end
        dpsm_pkg::ST_READY: begin
          // Transitions 3 and 7
          if (c_switch_on) begin
            next_state = dpsm_pkg::ST_SWON; // see R2
          end else if (c_dis_volt || c_qstop) begin
            next_state = dpsm_pkg::ST_SOD; // see R3
          end
        end
        dpsm_pkg::ST_SWON: begin
          // Transitions 4, 6 and 10
          if (c_enable) begin
            next_state = dpsm_pkg::ST_OPEN; // see R2
          end else if (c_shutdown) begin
            next_state = dpsm_pkg::ST_READY; // see R2
          end else if (c_dis_volt || c_qstop) begin
            next_state = dpsm_pkg::ST_SOD; // see R3
          end
        end
        dpsm_pkg::ST_OPEN: begin
          if (brk) begin
            // Ramp for shutdown or disable operation
            if (c_dis_volt) begin
              next_state = dpsm_pkg::ST_SOD;
              next_brk   = 1'b0;
            end else if (ramp_done_i) begin
              next_state = tgt; // see R14 R15
              next_brk   = 1'b0;
            end
          end else if (lim_hit || c_qstop) begin
            // Transition 11, option picks the reaction
            next_state = dpsm_pkg::ST_QSTOP; // see R3 R13
            next_hold  = 1'b0;
            next_brk   = (qs_opt == `DPSM_OPT_NORMAL) || (qs_opt == `DPSM_OPT_QUICK)
                         || (qs_opt == `DPSM_OPT_NORM_HOLD)
                         || (qs_opt == `DPSM_OPT_QUICK_HOLD); // see R10
            next_ramp  = ((qs_opt == `DPSM_OPT_QUICK) || (qs_opt == `DPSM_OPT_QUICK_HOLD))
                         ? dpsm_pkg::RAMP_QUICK : dpsm_pkg::RAMP_NORMAL; // see R11 R12
            next_tgt   = ((qs_opt == `DPSM_OPT_NORM_HOLD) || (qs_opt == `DPSM_OPT_QUICK_HOLD))
                         ? dpsm_pkg::ST_QSTOP : dpsm_pkg::ST_SOD; // see R11 R12
          end else if (c_dis_volt) begin
            // Transition 9
            next_state = dpsm_pkg::ST_SOD; // see R3
          end else if (c_shutdown) begin
            // Transition 8, reserved values act as 0
            next_tgt  = dpsm_pkg::ST_READY;
            next_ramp = dpsm_pkg::RAMP_NORMAL;
            if (sd_opt == `DPSM_OPT_NORMAL) begin
              next_brk = 1'b1; // see R14
            end else begin
              next_state = dpsm_pkg::ST_READY; // see R14
            end
          end else if (c_switch_on) begin
            // Transition 5, reserved values act as 0
            next_tgt  = dpsm_pkg::ST_SWON;
            next_ramp = dpsm_pkg::RAMP_NORMAL;
            if (do_opt == `DPSM_OPT_NORMAL) begin
              next_brk = 1'b1; // see R15
            end else begin
              next_state = dpsm_pkg::ST_SWON; // see R15
            end
          end
        end
        dpsm_pkg::ST_QSTOP: begin
          if (c_dis_volt) begin
            // Transition 12
            next_state = dpsm_pkg::ST_SOD; // see R3
            next_brk   = 1'b0;
            next_hold  = 1'b0;
          end else if (brk) begin
            if (ramp_done_i) begin
              next_brk = 1'b0;
              if (tgt == dpsm_pkg::ST_QSTOP) begin
                next_hold = 1'b1; // see R12
              end else begin
                next_state = tgt; // see R11
              end
            end
          end else if (hold) begin
            // Transition 16 on the edge only
            if (e_qs_ret) begin
              next_state = dpsm_pkg::ST_OPEN; // see R4 R12
              next_hold  = 1'b0;
            end
          end else begin
            // Option 0: driver already off
            next_state = dpsm_pkg::ST_SOD; // see R10
          end
        end
        dpsm_pkg::ST_FREACT: begin
          // Settle once the fault ramp ends
          if (!brk || ramp_done_i) begin
            next_state = dpsm_pkg::ST_FAULT; // see R16
            next_brk   = 1'b0;
          end
        end
        dpsm_pkg::ST_FAULT: begin
          // Transition 15
          if (e_freset) begin
            next_state = dpsm_pkg::ST_SOD; // see R17
          end
        end
        default: begin
          next_state = dpsm_pkg::ST_NOT_READY;
        end
      endcase
    end
    // Anything else keeps the state: see R18
    if (!next_brk) begin
      next_ramp = dpsm_pkg::RAMP_NONE;
    end
    next_drv = (next_state == dpsm_pkg::ST_OPEN) || next_brk
               || ((next_state == dpsm_pkg::ST_QSTOP) && next_hold); // see R10 R12
  end
  // State registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state    <= dpsm_pkg::ST_NOT_READY;
      tgt      <= dpsm_pkg::ST_SOD;
      ramp     <= dpsm_pkg::RAMP_NONE;
      brk      <= 1'b0;
      hold     <= 1'b0;
      drv      <= 1'b0;
      err_code <= 16'h0000;
    end else begin
      state    <= next_state;
      tgt      <= next_tgt;
      ramp     <= next_ramp;
      brk      <= next_brk;
      hold     <= next_hold;
      drv      <= next_drv;
      err_code <= next_err_code;
    end
  end
  // State word encoding
  always_comb begin
    case (state)
      dpsm_pkg::ST_NOT_READY: state_word = `DPSM_SW_NOT_READY; // see R5
      dpsm_pkg::ST_SOD:       state_word = `DPSM_SW_SOD; // see R5 R7
      dpsm_pkg::ST_READY:     state_word = `DPSM_SW_READY; // see R5
      dpsm_pkg::ST_SWON:      state_word = `DPSM_SW_SWON; // see R5
      dpsm_pkg::ST_OPEN:      state_word = `DPSM_SW_OPEN; // see R5
      dpsm_pkg::ST_QSTOP:     state_word = `DPSM_SW_QSTOP; // see R5
      dpsm_pkg::ST_FREACT:    state_word = `DPSM_SW_FREACT; // see R6
      dpsm_pkg::ST_FAULT:     state_word = `DPSM_SW_FAULT; // see R6
      default:                state_word = `DPSM_SW_NOT_READY;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and interrupts
  ////////////////////////////////////////////////////////////////////////////

  // Events raised by the state machine
  always_comb begin
    evt = '0;
    evt[`DPSM_EV_CHANGE] = (next_state != state);
    evt[`DPSM_EV_FAULT]  = (next_state == dpsm_pkg::ST_FREACT)
                           && (state != dpsm_pkg::ST_FREACT);
    evt[`DPSM_EV_LIMIT]  = lim_hit && (state == dpsm_pkg::ST_OPEN) && !brk;
    evt[`DPSM_EV_RAMP]   = brk && !next_brk;
  end
  // Writes, mode follow-up, read mux
  always_comb begin
    next_cmd      = cmd;
    next_mode_req = mode_req;
    next_qs_opt   = qs_opt;
    next_sd_opt   = sd_opt;
    next_do_opt   = do_opt;
    next_fr_opt   = fr_opt;
    next_irq_en   = irq_en;
    next_irq_stat = irq_stat;
    next_rdata    = 16'h0000;
    if (wr_i) begin
      case (addr_i)
        `DPSM_OFF_CMD:      next_cmd      = wdata_i; // see R1
        `DPSM_OFF_MODE_REQ: next_mode_req = wdata_i[MODE_W-1:0]; // see R8 R9
        `DPSM_OFF_QS_OPT:   next_qs_opt   = wdata_i;
        `DPSM_OFF_SD_OPT:   next_sd_opt   = wdata_i;
        `DPSM_OFF_DO_OPT:   next_do_opt   = wdata_i;
        `DPSM_OFF_FR_OPT:   next_fr_opt   = wdata_i;
        `DPSM_OFF_IRQ_EN:   next_irq_en   = wdata_i[`DPSM_EV_W-1:0];
        `DPSM_OFF_IRQ_CLR:  next_irq_stat = irq_stat & ~wdata_i[`DPSM_EV_W-1:0];
        default:            next_cmd      = cmd;
      endcase
    end
    // Set wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | evt;
    // Mode changes take effect unless a ramp is running
    next_mode_act = brk ? mode_act : mode_req; // see R8 R9
    if (rd_i) begin
      case (addr_i)
        `DPSM_OFF_CMD:      next_rdata = cmd;
        `DPSM_OFF_STATE:    next_rdata = state_word; // see R1
        `DPSM_OFF_MODE_REQ: next_rdata = 16'(mode_req);
        `DPSM_OFF_MODE_ACT: next_rdata = 16'(mode_act); // see R8
        `DPSM_OFF_QS_OPT:   next_rdata = qs_opt;
        `DPSM_OFF_SD_OPT:   next_rdata = sd_opt;
        `DPSM_OFF_DO_OPT:   next_rdata = do_opt;
        `DPSM_OFF_FR_OPT:   next_rdata = fr_opt;
        `DPSM_OFF_ERR_CODE: next_rdata = err_code; // see R16
        `DPSM_OFF_IRQ_STAT: next_rdata = 16'(irq_stat);
        `DPSM_OFF_IRQ_EN:   next_rdata = 16'(irq_en);
        default:            next_rdata = 16'h0000;
      endcase
    end
  end
  // Register file flops
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cmd      <= `DPSM_RST_CMD;
      mode_req <= MODE_W'(`DPSM_RST_MODE);
      mode_act <= MODE_W'(`DPSM_RST_MODE);
      qs_opt   <= `DPSM_RST_QS_OPT;
      sd_opt   <= `DPSM_RST_SD_OPT;
      do_opt   <= `DPSM_RST_DO_OPT;
      fr_opt   <= `DPSM_RST_FR_OPT;
      irq_en   <= '0;
      irq_stat <= '0;
      rdata    <= 16'h0000;
    end else begin
      cmd      <= next_cmd;
      mode_req <= next_mode_req;
      mode_act <= next_mode_act;
      qs_opt   <= next_qs_opt;
      sd_opt   <= next_sd_opt;
      do_opt   <= next_do_opt;
      fr_opt   <= next_fr_opt;
      irq_en   <= next_irq_en;
      irq_stat <= next_irq_stat;
      rdata    <= next_rdata;
    end
  end
  // Outputs
  assign rdata_o        = rdata;
  assign drive_enable_o = drv;
  assign brake_ramp_o   = ramp;
  assign mode_active_o  = mode_act;
  assign irq_o          = |(irq_stat & irq_en);

endmodule

`default_nettype wire

/* dv/dpsm_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module dpsm_top_asserts #(
  parameter int MODE_W = 8
) (
  // Clock and reset
  input wire logic              clk_i,
  input wire logic              rst_n_i,
  // Register port
  input wire logic [15:0]       addr_i,
  input wire logic [15:0]       wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [15:0]       rdata_o,
  // Drive side
  input wire logic              self_test_ok_i,
  input wire logic              limit_switch_i,
  input wire logic              fault_i,
  input wire logic [15:0]       fault_code_i,
  input wire logic              ramp_done_i,
  input wire logic              drive_enable_o,
  input wire logic [1:0]        brake_ramp_o,
  input wire logic [MODE_W-1:0] mode_active_o,
  // Interrupt
  input wire logic              irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////////
  // Read request of the state word
  sequence s_st_read;
    rd_i && addr_i == 16'h6041;
  endsequence
  // Read data only in the slot after a read
  property p_rdata_idle;
    !$past(rd_i) |-> rdata_o == 16'h0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  // Unmapped place reads zero
  property p_unmapped;
    rd_i && addr_i == 16'h3000 |=> rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Outputs quiet right after reset
  property p_reset_val;
    $rose(rst_n_i) |-> rdata_o == 16'h0000 && !drive_enable_o && brake_ramp_o == 2'h0
      && mode_active_o == '0 && !irq_o;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("outputs active after reset");
  // Only the three ramp codes exist
  property p_ramp_code;
    brake_ramp_o != 2'h3;
  endproperty
  a_ramp_code: assert property (p_ramp_code) else $error("bad ramp code");
  // Finished ramp ends braking
  property p_ramp_end;
    brake_ramp_o != 2'h0 && ramp_done_i && !fault_i |=> brake_ramp_o == 2'h0;
  endproperty
  a_ramp_end: assert property (p_ramp_end) else $error("braking kept after ramp end");
  // Requested mode comes into force
  property p_mode_follow;
    (wr_i && addr_i == 16'h6060) ##1 brake_ramp_o == 2'h0
      |=> mode_active_o == $past(wdata_i[MODE_W-1:0], 2);
  endproperty
  a_mode_follow: assert property (p_mode_follow) else $error("mode not taken");
  // State word shows only documented codes
  property p_st_codes;
    s_st_read |=> rdata_o inside {16'h0000, 16'h0040, 16'h0021, 16'h0023, 16'h0027,
      16'h0007, 16'h000F, 16'h0008};
  endproperty
  a_st_codes: assert property (p_st_codes) else $error("unknown state code");
  // Switch-on disabled keeps driver off
  property p_sod_off;
    s_st_read ##0 !fault_i ##1 (rdata_o == 16'h0040 && !fault_i) |=> !drive_enable_o;
  endproperty
  a_sod_off: assert property (p_sod_off) else $error("driver on while disabled");
endmodule
bind dpsm_top dpsm_top_asserts #(.MODE_W(MODE_W)) u_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i,
  .wr_i, .rd_i, .rdata_o, .self_test_ok_i, .limit_switch_i, .fault_i, .fault_code_i,
  .ramp_done_i, .drive_enable_o, .brake_ramp_o, .mode_active_o, .irq_o);
`default_nettype wire

/* dv/dpsm_drive_model.sv */
`timescale 1ns/1ps
`default_nettype none
module dpsm_drive_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Braking request and ramp length
  input  wire logic [1:0] brake_ramp_i,
  input  wire logic [4:0] delay_i,
  // Ramp finished pulse
  output logic            ramp_done_o
);
  logic [4:0] cnt; // Cycles spent braking
  // Counts a ramp, then pulses done for one cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt         <= 5'h00;
      ramp_done_o <= 1'b0;
    end else begin
      ramp_done_o <= 1'b0;
      if (brake_ramp_i == 2'h0) begin
        cnt <= 5'h00;
      end else if (!ramp_done_o) begin
        if (cnt == delay_i) begin // Motor at rest
          ramp_done_o <= 1'b1;
          cnt         <= 5'h00;
        end else begin
          cnt <= cnt + 5'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* dv/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i, rst_n_i, wr_i, rd_i, self_test_ok_i, limit_switch_i, fault_i;
  logic        ramp_done_i, drive_enable_o, irq_o;
  logic [15:0] addr_i, wdata_i, rdata_o, fault_code_i;
  logic [1:0]  brake_ramp_o;
  logic [7:0]  mode_active_o;
  logic [4:0]  delay;
  int          n_mismatch, tests_run, i;
  logic [15:0] opts [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
  // Design and drive model
  dpsm_top dut (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .self_test_ok_i,
    .limit_switch_i, .fault_i, .fault_code_i, .ramp_done_i, .drive_enable_o, .brake_ramp_o,
    .mode_active_o, .irq_o);
  dpsm_drive_model u_drive (.clk_i, .rst_n_i, .brake_ramp_i(brake_ramp_o), .delay_i(delay),
    .ramp_done_o(ramp_done_i));
  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    if (n_mismatch == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // One-cycle register write
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask
  // One-cycle read, data checked in the slot after
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp);
  endtask
  // Bounded wait for braking to end
  task automatic wait_idle;
    int k;
    k = 0;
    while (brake_ramp_o !== 2'h0 && k < 60) begin
      cyc(1);
      k++;
    end
    if (k == 60) begin
      $display("wrong value at %0t: braking never ended", $time);
      n_mismatch++;
      print_verdict();
    end
  endtask
  task automatic reset_dut(input logic ok);
    @(posedge clk_i);
    rst_n_i        <= 1'b0;
    self_test_ok_i <= ok;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
  endtask
  task automatic go_open;
    wr(16'h6040, 16'h0006);
    wr(16'h6040, 16'h0007);
    wr(16'h6040, 16'h000F);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst_n_i, wr_i, rd_i, self_test_ok_i, limit_switch_i, fault_i} = '0;
    {addr_i, wdata_i, fault_code_i} = '0;
    delay = 5'd4;
    reset_dut(1'b0);
    rd(16'h6041, 16'h0000); // no self-test
    reset_dut(1'b1);
    rd(16'h6041, 16'h0040); // idle entry
    rd(16'h605A, 16'h0002); // option reset
    rd(16'h605B, 16'h0001); // option reset
    rd(16'h605C, 16'h0001); // option reset
    rd(16'h3000, 16'h0000); // unmapped
    wr(16'h6041, 16'h0023); // read-only write
    wr(16'h6040, 16'h0007); // no valid move
    rd(16'h6041, 16'h0040); // kept
    wr(16'h6060, 16'h0003); // mode while idle
    cyc(2);
    chk({8'h00, mode_active_o}, 16'h0003); // mode in force
    rd(16'h6061, 16'h0003); // mode readback
    wr(16'h6040, 16'h0006);
    rd(16'h6041, 16'h0021); // ready
    wr(16'h6040, 16'h0007);
    rd(16'h6041, 16'h0023); // switched on
    wr(16'h6040, 16'h000F);
    rd(16'h6041, 16'h0027); // enabled
    chk(16'(drive_enable_o), 16'h0001); // driver on
    wr(16'h6040, 16'h0080); // bit 7 blocks normal commands
    rd(16'h6041, 16'h0027); // kept
    // Fault with reaction ramp and interrupt
    wr(16'h2002, 16'h0002);
    wr(16'h2001, 16'h000F);
    delay = 5'd20;
    @(posedge clk_i);
    fault_i      <= 1'b1;
    fault_code_i <= 16'h1234;
    @(posedge clk_i);
    fault_i <= 1'b0;
    #1;
    rd(16'h6041, 16'h000F); // reacting
    chk({14'h0, brake_ramp_o}, 16'h0002); // default fault ramp
    wait_idle();
    rd(16'h6041, 16'h0008); // fault kept under level bit 7
    rd(16'h1003, 16'h1234); // error code
    chk(16'(irq_o), 16'h0001); // fault event raised
    wr(16'h2001, 16'h0002);
    chk(16'(irq_o), 16'h0000); // event cleared
    wr(16'h6040, 16'h0000);
    rd(16'h6041, 16'h0008); // still fault
    wr(16'h6040, 16'h0080);
    rd(16'h6041, 16'h0040); // fault reset edge
    delay = 5'd4;
    // Quick stop under every option
    for (i = 0; i < 5; i++) begin
      go_open();
      wr(16'h605A, opts[i]);
      wr(16'h6040, 16'h000B); // bit 2 clear
      cyc(1);
      chk({14'h0, brake_ramp_o}, (opts[i] == 0) ? 16'h0 : (opts[i][0] ? 16'h1 : 16'h2));
      wait_idle();
      rd(16'h6041, (opts[i] > 4) ? 16'h0007 : 16'h0040); // end state
      chk(16'(drive_enable_o), 16'(opts[i] > 4)); // driver
      if (opts[i] > 4) begin
        wr(16'h6040, 16'h000F);
        rd(16'h6041, 16'h0027); // return on edge
        wr(16'h6040, 16'h0000);
        rd(16'h6041, 16'h0040); // voltage off
      end
    end
    // Limit switch quick stop with bit 2 held high
    go_open();
    @(posedge clk_i);
    limit_switch_i <= 1'b1;
    cyc(6);
    rd(16'h6041, 16'h0007); // limit stop
    wait_idle();
    rd(16'h6041, 16'h0007); // level gives no return
    @(posedge clk_i);
    limit_switch_i <= 1'b0;
    wr(16'h6040, 16'h000B);
    wr(16'h6040, 16'h000F);
    rd(16'h6041, 16'h0027); // return
    // Disable operation immediate, shutdown with ramp
    wr(16'h605C, 16'h0000);
    wr(16'h6040, 16'h0007);
    rd(16'h6041, 16'h0023); // switched on
    chk(16'(drive_enable_o), 16'h0000); // driver off
    wr(16'h6040, 16'h000F);
    wr(16'h6040, 16'h0006);
    cyc(1);
    chk({14'h0, brake_ramp_o}, 16'h0001); // normal ramp
    wait_idle();
    rd(16'h6041, 16'h0021); // ready
    wr(16'h6040, 16'h0000);
    rd(16'h6041, 16'h0040); // voltage off
    print_verdict();
  end
endmodule
`default_nettype wire
